// ===== core/sdram_pin_regs.vh
// constants for the sdram pin control block
`ifndef SDRAM_PIN_REGS_VH
`define SDRAM_PIN_REGS_VH
// command codes on {row strobe, column strobe, write strobe}, chip select low
`define CMD_MODE_LOAD   3'h0
`define CMD_REFRESH     3'h1
`define CMD_PRECHARGE   3'h2
`define CMD_ACTIVATE    3'h3
`define CMD_WRITE       3'h4
`define CMD_READ        3'h5
`define CMD_BURST_STOP  3'h6
`define CMD_NOP         3'h7
// low-activity states
`define LP_ACTIVE       2'h0
`define LP_POWER_DOWN   2'h1
`define LP_SUSPEND      2'h2
`define LP_SELF_REFRESH 2'h3
// mode word layout and reset value (latency 2, burst 1)
`define MODE_RESET      12'h020
`define MODE_BL_LSB     0
`define MODE_CL_LSB     4
`define MODE_CL_THREE   3'h3
// address bit that selects auto precharge / all banks
`define AP_BIT          10
// read mask to output enable latency, in clocks
`define READ_MASK_LAT   2
`endif

// ===== core/sdram_byte_lane.v
// one byte lane: byte storage, masked write, masked read drive
`timescale 1ns/1ns
`default_nettype none
`include "sdram_pin_regs.vh"
module sdram_byte_lane #(
  parameter AW = 22
) (
  // clock and reset
  input  wire          clk,
  input  wire          arst_n,
  // qualified edge and mask
  input  wire          edge_en,
  input  wire          mask,
  // write beat
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [7:0]    wr_data,
  // read beat, already aligned to the output load edge
  input  wire          rd_en,
  input  wire [AW-1:0] rd_addr,
  // pin side
  output reg  [7:0]    rd_data_r,
  output wire          oe_n
);
  reg [7:0] mem [0:(1<<AW)-1];
  reg       mask_d1_r;
  reg       mask_d2_r;
  reg       drive_r;

  // masked byte is dropped, location keeps its old content
  always @(posedge clk) begin
    if (edge_en && wr_en && !mask) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 8'h00;
      mask_d1_r <= 1'b1;
      mask_d2_r <= 1'b1;
      drive_r   <= 1'b0;
    end else if (edge_en) begin
      mask_d1_r <= mask;
      mask_d2_r <= mask_d1_r;
      drive_r   <= rd_en;
      if (rd_en) begin
        rd_data_r <= mem[rd_addr];
      end
    end
  end

  // high impedance whenever the mask seen two edges back was high
  assign oe_n = ~drive_r | mask_d2_r;
endmodule
`default_nettype wire

// ===== core/sdram_pin_control.v
// sdram device pin control: command decode, bursts, byte masking
//
// What this block does
// - An edge counts only when the clock gate input is high at that edge.
// - With the clock gate low the device sits in power-down, clock suspend or self refresh.
// - The clock gate is used as a raw level, never registered before use.
// - All other inputs except the asynchronous reset are sampled only on the rising clock edge.
// - A command is taken only on an edge where chip select is low.
// - With chip select high the state is kept and running bursts carry on.
// - Lower mask governs data bits 7..0, upper mask bits 15..8, independently.
// - On reads a byte is driven only when its mask was low, else it floats.
// - On writes a byte is stored only when its mask is low, else it is dropped.
// - The command is decoded from row strobe, column strobe and write strobe together.
// - Read output enable follows the mask sampled two edges earlier.
// - Write masking uses the mask sampled on the same edge as the data.
`timescale 1ns/1ns
`default_nettype none
`include "sdram_pin_regs.vh"
module sdram_pin_control #(
  parameter ROW_W = 12,
  parameter COL_W = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // command pins
  input  wire             clk_gate,
  input  wire             cs_n,
  input  wire             ras_n,
  input  wire             cas_n,
  input  wire             we_n,
  input  wire [11:0]      addr,
  input  wire [1:0]       bank,
  // byte masks
  input  wire             lower_byte_mask,
  input  wire             upper_byte_mask,
  // data lines, split into in, out and active-low enable per byte
  input  wire [15:0]      data_lines_in,
  output wire [15:0]      data_lines_out,
  output wire [1:0]       data_lines_oe_n,
  // status
  output reg  [1:0]       low_power_state_r,
  output reg  [3:0]       bank_open_r
);
  localparam AW = 2 + ROW_W + COL_W;

  reg  [11:0]        mode_r;
  reg  [4*ROW_W-1:0] row_flat_r;
  reg                bst_act_r;
  reg                bst_wr_r;
  reg                bst_ap_r;
  reg  [1:0]         bst_bank_r;
  reg  [COL_W-1:0]   bst_col_r;
  reg  [8:0]         bst_left_r;
  reg                rq_d1_r;
  reg                rq_d2_r;
  reg  [AW-1:0]      rq_addr_d1_r;
  reg  [AW-1:0]      rq_addr_d2_r;

  wire               edge_en;
  wire               cmd_ok;
  wire [2:0]         cmd;
  wire               is_rd;
  wire               is_wr;
  wire               is_act;
  wire               is_pre;
  wire               is_ref;
  wire               is_stop;
  wire               is_mode;
  wire               new_bst;
  wire               stop_bst;
  wire               beat_go;
  wire               beat_wr;
  wire [1:0]         beat_bank;
  wire [COL_W-1:0]   beat_col;
  wire [ROW_W-1:0]   beat_row;
  wire [AW-1:0]      beat_addr;
  wire [8:0]         bl_cur;
  wire               cl_three;
  wire               fetch;
  wire [AW-1:0]      fetch_addr;

  function [8:0] bl_of;
    input [2:0] f;
    begin
      case (f)
        3'h0:    bl_of = 9'h001;
        3'h1:    bl_of = 9'h002;
        3'h2:    bl_of = 9'h004;
        3'h3:    bl_of = 9'h008;
        3'h7:    bl_of = 9'h100;
        default: bl_of = 9'h001;
      endcase
    end
  endfunction

  // gate level taken straight from the pin so it acts without a clock delay
  assign edge_en = clk_gate;
  assign cmd_ok  = edge_en & ~cs_n;
  assign cmd     = {ras_n, cas_n, we_n};
  assign is_rd   = cmd_ok & (cmd == `CMD_READ) & bank_open_r[bank];
  assign is_wr   = cmd_ok & (cmd == `CMD_WRITE) & bank_open_r[bank];
  assign is_act  = cmd_ok & (cmd == `CMD_ACTIVATE);
  assign is_pre  = cmd_ok & (cmd == `CMD_PRECHARGE);
  assign is_ref  = cmd_ok & (cmd == `CMD_REFRESH);
  assign is_stop = cmd_ok & (cmd == `CMD_BURST_STOP);
  assign is_mode = cmd_ok & (cmd == `CMD_MODE_LOAD) & (bank_open_r == 4'h0);

  assign bl_cur   = bl_of(mode_r[`MODE_BL_LSB+2:`MODE_BL_LSB]);
  assign cl_three = (mode_r[`MODE_CL_LSB+2:`MODE_CL_LSB] == `MODE_CL_THREE);

  // chip select high never cuts a burst short
  assign new_bst  = is_rd | is_wr;
  assign stop_bst = is_stop | (is_pre & (addr[`AP_BIT] | (bank == bst_bank_r)));
  assign beat_go  = new_bst | (edge_en & bst_act_r & ~stop_bst);

  assign beat_wr   = new_bst ? is_wr : bst_wr_r;
  assign beat_bank = new_bst ? bank : bst_bank_r;
  assign beat_col  = new_bst ? addr[COL_W-1:0] : bst_col_r;
  assign beat_row  = row_flat_r[beat_bank*ROW_W +: ROW_W];
  assign beat_addr = {beat_bank, beat_row, beat_col};

  // burst engine and bank bookkeeping
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r      <= `MODE_RESET;
      row_flat_r  <= {(4*ROW_W){1'b0}};
      bank_open_r <= 4'h0;
      bst_act_r   <= 1'b0;
      bst_wr_r    <= 1'b0;
      bst_ap_r    <= 1'b0;
      bst_bank_r  <= 2'h0;
      bst_col_r   <= {COL_W{1'b0}};
      bst_left_r  <= 9'h000;
    end else if (edge_en) begin
      if (is_mode) begin
        mode_r <= addr;
      end
      if (is_act) begin
        row_flat_r[bank*ROW_W +: ROW_W] <= addr[ROW_W-1:0];
        bank_open_r[bank]               <= 1'b1;
      end
      if (is_pre) begin
        if (addr[`AP_BIT]) begin
          bank_open_r <= 4'h0;
        end else begin
          bank_open_r[bank] <= 1'b0;
        end
      end
      if (new_bst) begin
        bst_wr_r   <= is_wr;
        bst_ap_r   <= addr[`AP_BIT];
        bst_bank_r <= bank;
        bst_col_r  <= addr[COL_W-1:0] + 1'b1;
        bst_left_r <= bl_cur - 9'h001;
        bst_act_r  <= (bl_cur != 9'h001);
        if (bl_cur == 9'h001 && addr[`AP_BIT]) begin
          bank_open_r[bank] <= 1'b0;
        end
      end else if (beat_go) begin
        bst_col_r  <= bst_col_r + 1'b1;
        bst_left_r <= bst_left_r - 9'h001;
        bst_act_r  <= (bst_left_r != 9'h001);
        if (bst_left_r == 9'h001 && bst_ap_r) begin
          bank_open_r[bst_bank_r] <= 1'b0;
        end
      end else if (stop_bst) begin
        bst_act_r <= 1'b0;
      end
    end
  end

  // read beats wait latency-1 qualified edges before the output load
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rq_d1_r      <= 1'b0;
      rq_d2_r      <= 1'b0;
      rq_addr_d1_r <= {AW{1'b0}};
      rq_addr_d2_r <= {AW{1'b0}};
    end else if (edge_en) begin
      rq_d1_r      <= beat_go & ~beat_wr;
      rq_d2_r      <= rq_d1_r;
      rq_addr_d1_r <= beat_addr;
      rq_addr_d2_r <= rq_addr_d1_r;
    end
  end

  assign fetch      = cl_three ? rq_d2_r : rq_d1_r;
  assign fetch_addr = cl_three ? rq_addr_d2_r : rq_addr_d1_r;

  // low-activity state follows every physical edge, gated or not
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_power_state_r <= `LP_ACTIVE;
    end else if (clk_gate) begin
      low_power_state_r <= `LP_ACTIVE;
    end else if (low_power_state_r == `LP_ACTIVE) begin
      if (!cs_n && cmd == `CMD_REFRESH) begin
        low_power_state_r <= `LP_SELF_REFRESH;
      end else if (bst_act_r || rq_d1_r || rq_d2_r) begin
        low_power_state_r <= `LP_SUSPEND;
      end else begin
        low_power_state_r <= `LP_POWER_DOWN;
      end
    end
  end

  // lower mask on bits 7..0, upper mask on bits 15..8
  sdram_byte_lane #(
    .AW (AW)
  ) u_lane_lo (
    .clk       (clk),
    .arst_n    (arst_n),
    .edge_en   (edge_en),
    .mask      (lower_byte_mask),
    .wr_en     (beat_go & beat_wr),
    .wr_addr   (beat_addr),
    .wr_data   (data_lines_in[7:0]),
    .rd_en     (fetch),
    .rd_addr   (fetch_addr),
    .rd_data_r (data_lines_out[7:0]),
    .oe_n      (data_lines_oe_n[0])
  );

  sdram_byte_lane #(
    .AW (AW)
  ) u_lane_hi (
    .clk       (clk),
    .arst_n    (arst_n),
    .edge_en   (edge_en),
    .mask      (upper_byte_mask),
    .wr_en     (beat_go & beat_wr),
    .wr_addr   (beat_addr),
    .wr_data   (data_lines_in[15:8]),
    .rd_en     (fetch),
    .rd_addr   (fetch_addr),
    .rd_data_r (data_lines_out[15:8]),
    .oe_n      (data_lines_oe_n[1])
  );

  // refresh has no array effect in this model
  wire unused_ok = is_ref;
endmodule
`default_nettype wire

// ===== verif/sdram_ctrl_model.sv
// controller-side pin driver for the sdram pin block
`timescale 1ns/1ns
`default_nettype none
`include "sdram_pin_regs.vh"
module sdram_ctrl_model (
  // clock
  input  wire logic        clk,
  // pins toward the device
  output var  logic        clk_gate,
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [11:0] addr,
  output var  logic [1:0]  bank,
  output var  logic        lower_byte_mask,
  output var  logic        upper_byte_mask,
  output var  logic [15:0] data_lines_in
);
  initial begin
    clk_gate = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = `CMD_NOP;
    addr = 12'h000;
    bank = 2'h0;
    {upper_byte_mask, lower_byte_mask} = 2'h3;
    data_lines_in = 16'h0000;
  end
  // launched just after an edge so every pin is settled at the next one
  task automatic cmd(input logic g, input logic cs, input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [1:0] m, input logic [15:0] d);
    @(posedge clk);
    clk_gate <= g;
    cs_n <= cs;
    {ras_n, cas_n, we_n} <= c;
    addr <= a;
    bank <= b;
    {upper_byte_mask, lower_byte_mask} <= m;
    // data is only driven on writes; otherwise show a changing pattern
    data_lines_in <= (c == `CMD_WRITE) ? d : ~data_lines_in;
  endtask
endmodule
`default_nettype wire

// ===== verif/sdram_pin_monitor.sv
// port-level assertions for the sdram pin block
`timescale 1ns/1ns
`default_nettype none
`include "sdram_pin_regs.vh"
module sdram_pin_monitor (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // pins
  input  wire logic        clk_gate,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [11:0] addr,
  input  wire logic [1:0]  bank,
  input  wire logic        lower_byte_mask,
  input  wire logic        upper_byte_mask,
  input  wire logic [15:0] data_lines_out,
  input  wire logic [1:0]  data_lines_oe_n,
  input  wire logic [1:0]  low_power_state_r,
  input  wire logic [3:0]  bank_open_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_cmd(logic [2:0] c);
    clk_gate && !cs_n && ({ras_n, cas_n, we_n} == c);
  endsequence
  sequence s_two_valid;
    $past(clk_gate) && $past(clk_gate, 2);
  endsequence
  a_gate_hold: assert property (!clk_gate |=> $stable(data_lines_out) && $stable(data_lines_oe_n) && $stable(bank_open_r)) else $error("outputs moved on a gated edge");
  a_gate_lowpower: assert property (!clk_gate |=> low_power_state_r != `LP_ACTIVE) else $error("no low power state with gate low");
  a_gate_wake: assert property (clk_gate |=> low_power_state_r == `LP_ACTIVE) else $error("not active after a valid edge");
  a_cs_ignore: assert property (clk_gate && cs_n |=> $stable(bank_open_r)) else $error("bank state moved while deselected");
  a_act_opens: assert property (s_cmd(`CMD_ACTIVATE) |=> bank_open_r[$past(bank)]) else $error("activate did not open bank");
  a_pre_one: assert property (s_cmd(`CMD_PRECHARGE) ##0 !addr[10] |=> !bank_open_r[$past(bank)]) else $error("bank precharge failed");
  a_pre_all: assert property (s_cmd(`CMD_PRECHARGE) ##0 addr[10] |=> bank_open_r == 4'h0) else $error("all-bank precharge failed");
  a_lower_mask: assert property (s_two_valid ##0 !data_lines_oe_n[0] |-> !$past(lower_byte_mask, 2)) else $error("lower byte driven while masked");
  a_upper_mask: assert property (s_two_valid ##0 !data_lines_oe_n[1] |-> !$past(upper_byte_mask, 2)) else $error("upper byte driven while masked");
endmodule
bind sdram_pin_control sdram_pin_monitor u_mon (.clk(clk), .arst_n(arst_n), .clk_gate(clk_gate), .cs_n(cs_n),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank(bank), .lower_byte_mask(lower_byte_mask),
  .upper_byte_mask(upper_byte_mask), .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
  .low_power_state_r(low_power_state_r), .bank_open_r(bank_open_r));
`default_nettype wire

// ===== verif/sdram_pin_control_test.sv
// self-checking bench for the sdram pin block
`timescale 1ns/1ns
`default_nettype none
`include "sdram_pin_regs.vh"
module sdram_pin_control_test;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  wire logic   clk_gate, cs_n, ras_n, cas_n, we_n, lower_byte_mask, upper_byte_mask;
  wire logic [11:0] addr;
  wire logic [1:0]  bank, data_lines_oe_n, low_power_state_r;
  wire logic [15:0] data_lines_in, data_lines_out;
  wire logic [3:0]  bank_open_r;
  int          n_fail = 0;
  int          check_count = 0;
  always #5 clk = ~clk;
  sdram_ctrl_model u_ctrl (.clk(clk), .clk_gate(clk_gate), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .bank(bank), .lower_byte_mask(lower_byte_mask), .upper_byte_mask(upper_byte_mask),
    .data_lines_in(data_lines_in));
  // small geometry keeps the storage array tiny
  sdram_pin_control #(.ROW_W(2), .COL_W(4)) u_dut (.clk(clk), .arst_n(arst_n), .clk_gate(clk_gate), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank(bank), .lower_byte_mask(lower_byte_mask),
    .upper_byte_mask(upper_byte_mask), .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe_n(data_lines_oe_n), .low_power_state_r(low_power_state_r), .bank_open_r(bank_open_r));
  task automatic end_sim;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a, input logic [1:0] m,
                    input logic [15:0] d);
    u_ctrl.cmd(1'b1, 1'b0, c, b, a, m, d);
  endtask
  task automatic nop;
    op(`CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0000);
  endtask
  // read one word; masked bytes are left out of the data compare
  task automatic rd(input logic [1:0] b, input logic [11:0] a, input logic [1:0] m, input logic [15:0] exp);
    op(`CMD_READ, b, a, m, 16'h0000);
    nop;
    nop;
    #1;
    chk(16'(data_lines_oe_n), 16'(m));
    chk(data_lines_out & {{8{~m[1]}}, {8{~m[0]}}}, exp);
  endtask
  task automatic t_reset;
    chk(16'(data_lines_oe_n), 16'h0003);
    chk(16'(bank_open_r), 16'h0000);
  endtask
  task automatic t_masks;
    op(`CMD_ACTIVATE, 2'h1, 12'h001, 2'h0, 16'h0000);
    op(`CMD_WRITE, 2'h1, 12'h003, 2'h0, 16'hA55A);
    rd(2'h1, 12'h003, 2'h0, 16'hA55A);
    op(`CMD_WRITE, 2'h1, 12'h003, 2'h2, 16'h1234);
    rd(2'h1, 12'h003, 2'h0, 16'hA534);
    rd(2'h1, 12'h003, 2'h1, 16'hA500);
    rd(2'h1, 12'h003, 2'h2, 16'h0034);
  endtask
  task automatic t_select;
    u_ctrl.cmd(1'b1, 1'b1, `CMD_ACTIVATE, 2'h2, 12'h000, 2'h0, 16'h0000);
    nop;
    #1;
    chk(16'(bank_open_r), 16'h0002);
  endtask
  task automatic t_gate;
    logic [2:0] c [2] = '{`CMD_ACTIVATE, `CMD_REFRESH};
    logic [1:0] s [2] = '{`LP_POWER_DOWN, `LP_SELF_REFRESH};
    for (int i = 0; i < 2; i++) begin
      u_ctrl.cmd(1'b0, 1'b0, c[i], 2'h2, 12'h000, 2'h0, 16'h0000);
      nop;
      #1;
      chk(16'(low_power_state_r), 16'(s[i]));
      chk(16'(bank_open_r), 16'h0002);
      nop;
      #1;
      chk(16'(low_power_state_r), 16'(`LP_ACTIVE));
    end
  endtask
  task automatic t_banks;
    op(`CMD_ACTIVATE, 2'h0, 12'h000, 2'h0, 16'h0000);
    op(`CMD_PRECHARGE, 2'h1, 12'h000, 2'h0, 16'h0000);
    nop;
    #1;
    chk(16'(bank_open_r), 16'h0001);
    op(`CMD_BURST_STOP, 2'h0, 12'h000, 2'h0, 16'h0000);
    op(`CMD_PRECHARGE, 2'h3, 12'h400, 2'h0, 16'h0000);
    nop;
    #1;
    chk(16'(bank_open_r), 16'h0000);
    op(`CMD_MODE_LOAD, 2'h0, `MODE_RESET, 2'h0, 16'h0000);
    op(`CMD_ACTIVATE, 2'h0, 12'h002, 2'h0, 16'h0000);
    op(`CMD_WRITE, 2'h0, 12'h005, 2'h0, 16'hC33C);
    rd(2'h0, 12'h005, 2'h0, 16'hC33C);
  endtask
  // latency three, length four, auto precharge; write beat 1 goes out deselected with the lower byte masked
  // the model shows the inverse of the last word on non-write cycles, so write beats alternate
  task automatic t_burst;
    logic [1:0]  m [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    logic [15:0] e [4] = '{16'h1E87, 16'h003C, 16'h1E00, 16'h0000};
    op(`CMD_PRECHARGE, 2'h0, 12'h400, 2'h0, 16'h0000);
    op(`CMD_MODE_LOAD, 2'h0, 12'h032, 2'h0, 16'h0000);
    op(`CMD_ACTIVATE, 2'h0, 12'h002, 2'h0, 16'h0000);
    op(`CMD_WRITE, 2'h0, 12'h404, 2'h0, 16'h1E87);
    u_ctrl.cmd(1'b1, 1'b1, `CMD_NOP, 2'h0, 12'h000, 2'h1, 16'h0000);
    nop;
    nop;
    op(`CMD_ACTIVATE, 2'h0, 12'h002, 2'h0, 16'h0000);
    #1;
    chk(16'(bank_open_r), 16'h0000);
    op(`CMD_READ, 2'h0, 12'h004, 2'h0, 16'h0000);
    op(`CMD_NOP, 2'h0, 12'h000, m[0], 16'h0000);
    op(`CMD_NOP, 2'h0, 12'h000, m[1], 16'h0000);
    for (int i = 0; i < 4; i++) begin
      op(`CMD_NOP, 2'h0, 12'h000, (i < 2) ? m[i+2] : 2'h0, 16'h0000);
      #1;
      chk(16'(data_lines_oe_n), 16'(m[i]));
      chk(data_lines_out & {{8{~m[i][1]}}, {8{~m[i][0]}}}, e[i]);
    end
    // gate dropped while a burst runs parks the device in clock suspend
    op(`CMD_READ, 2'h0, 12'h004, 2'h0, 16'h0000);
    u_ctrl.cmd(1'b0, 1'b0, `CMD_NOP, 2'h0, 12'h000, 2'h0, 16'h0000);
    nop;
    #1;
    chk(16'(low_power_state_r), 16'(`LP_SUSPEND));
  endtask
  // a hang counts as a failure
  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    t_reset;
    arst_n <= 1'b1;
    t_masks;
    t_select;
    t_gate;
    t_banks;
    t_burst;
    end_sim;
  end
endmodule
`default_nettype wire
